/* src/itec_pkg.sv */
// Constants, register map and carrier types for the interval timer and
// event counter.
// Assumes one 10 MHz clock and a synchronous active-low reset.
package itec_pkg;

    // ------------------------------------------------------------
    // Timing chain
    // ------------------------------------------------------------
    localparam int unsigned STATE_DIV = 3;
    localparam int unsigned CYCLE_DIV = 5;
    localparam int unsigned PRESCALE_DIV = 32;
    localparam logic [1:0] STATE_LAST = 2'(STATE_DIV - 1);
    localparam logic [2:0] CYCLE_LAST = 3'(CYCLE_DIV - 1);
    localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);

    // ------------------------------------------------------------
    // Count register
    // ------------------------------------------------------------
    localparam int unsigned COUNT_W = 8;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // ------------------------------------------------------------
    // Register map (plain port, 8-bit data)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 2;
    localparam logic [1:0] REG_COUNT = 2'h0;
    localparam logic [1:0] REG_CMD = 2'h1;
    localparam logic [1:0] REG_FLAG_TEST = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Command codes written to REG_CMD
    localparam logic [7:0] CMD_START_INTERVAL = 8'h01;
    localparam logic [7:0] CMD_START_EVENT = 8'h02;
    localparam logic [7:0] CMD_HALT = 8'h03;
    localparam logic [7:0] CMD_ALLOW_COUNT_IRQ = 8'h04;
    localparam logic [7:0] CMD_BLOCK_COUNT_IRQ = 8'h05;
    localparam logic [7:0] CMD_ALLOW_HOST_IRQ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_HOST_IRQ = 8'h07;

    // ------------------------------------------------------------
    // Interrupt vectors
    // ------------------------------------------------------------
    localparam int unsigned VEC_W = 3;
    localparam logic [2:0] VEC_HOST = 3'h3;
    localparam logic [2:0] VEC_TIMER = 3'h7;
    localparam logic [2:0] VEC_NONE = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ITEC_SRC_INTERVAL,
        ITEC_SRC_EVENT
    } itec_src_t;

    typedef enum logic [1:0] {
        ITEC_IRQ_IDLE,
        ITEC_IRQ_CALL,
        ITEC_IRQ_SERVICE
    } itec_irq_state_t;

    // Status word, bit 7 down to bit 0
    typedef struct packed {
        logic overflow_flag;
        logic in_service;
        logic host_irq_en;
        logic host_pending;
        logic timer_pending;
        logic count_irq_en;
        logic event_mode;
        logic running;
    } itec_status_t;

    // Timing strobes handed from the chain to the counter
    typedef struct packed {
        logic state_tick;
        logic cycle_tick;
    } itec_ticks_t;

endpackage : itec_pkg

/* src/itec_timing.sv */
// Oscillator timing chain: state counter and machine cycle counter.
// Assumes clk is the oscillator and rst_n is synchronous, active low.
`timescale 1ns/1ns
module itec_timing (
    input wire logic clk,
    input wire logic rst_n,
    output itec_pkg::itec_ticks_t ticks,
    output logic machine_cycle_strobe
);

    logic [1:0] state_cnt;
    logic [2:0] cycle_cnt;
    logic state_end;

    // ------------------------------------------------------------
    // State counter
    // ------------------------------------------------------------
    assign state_end = (state_cnt == itec_pkg::STATE_LAST);
    assign ticks = '{state_tick: state_end,
                     cycle_tick: state_end &&
                         (cycle_cnt == itec_pkg::CYCLE_LAST)};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_cnt <= 2'h0;
        end else if (state_end) begin
            state_cnt <= 2'h0;
        end else begin
            state_cnt <= state_cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycle_cnt <= 3'h0;
        end else if (ticks.cycle_tick) begin
            cycle_cnt <= 3'h0;
        end else if (state_end) begin
            cycle_cnt <= cycle_cnt + 3'h1;
        end
    end

    // High during the first state of each cycle; a free-running clock out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            machine_cycle_strobe <= 1'b0;
        end else begin
            machine_cycle_strobe <= (cycle_cnt == 3'h0);
        end
    end

endmodule : itec_timing

/* src/itec_counter.sv */
// Interval timer and event counter with its interrupt arbitration.
// Assumes a 10 MHz clk, synchronous active-low rst_n, a plain register
// port driven by a single master, and a core that acknowledges vectors.
`timescale 1ns/1ns

// What this block does
// - Oscillator divided by three per state
// - States divided by five; strobe output
// - 8-bit count from selected source
// - Program loads and reads the count
// - Reset or halt stops until restart
// - Count up, wrap to zero, continue
// - Wrap sets flag and timer request
// - Flag test clears flag; reset too
// - Reset clears count and flag
// - Timer request latched, ORed with host
// - Separate timer interrupt enable commands
// - Enabled overflow calls address seven
// - Host first; timer taken after return
// - Timer request cleared on service entry
// - Event start selects pin, keeps count
// - Count each falling pin edge
// - Sample pin once per machine cycle
// - Interval start selects prescaler, keeps count
// - Prescaler divides cycle strobe by 32
module itec_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic count_input_pin,
    input wire logic host_in_full,
    input wire logic int_ack,
    input wire logic int_ret,
    output logic machine_cycle_strobe,
    output logic int_req,
    output logic [2:0] int_vector,
    output logic overflow_flag
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    itec_pkg::itec_ticks_t ticks;
    itec_pkg::itec_src_t src;
    itec_pkg::itec_irq_state_t irq_state;
    itec_pkg::itec_status_t status;
    logic [7:0] count;
    logic running;
    logic [4:0] prescale;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic count_pulse;
    logic interval_pulse;
    logic event_pulse;
    logic load_wr;
    logic cmd_wr;
    logic flag_test;
    logic wrap;
    logic count_irq_en;
    logic host_irq_en;
    logic timer_pending;
    logic host_pending;
    logic host_want;
    logic timer_want;
    logic any_want;

    function automatic logic is_cmd(input logic [7:0] data,
                                    input logic [7:0] code);
        is_cmd = (data == code);
    endfunction : is_cmd

    function automatic logic [7:0] wrap_inc(input logic [7:0] value);
        wrap_inc = (value == itec_pkg::COUNT_MAX) ?
            itec_pkg::COUNT_RESET : value + 8'h01;
    endfunction : wrap_inc

    // ------------------------------------------------------------
    // Timing chain
    // ------------------------------------------------------------
    itec_timing u_timing (
        .clk(clk),
        .rst_n(rst_n),
        .ticks(ticks),
        .machine_cycle_strobe(machine_cycle_strobe)
    );

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    assign load_wr = wr && (addr == itec_pkg::REG_COUNT);
    assign cmd_wr = wr && (addr == itec_pkg::REG_CMD);
    // Reading the flag-test register is the jump-on-flag test
    assign flag_test = rd && (addr == itec_pkg::REG_FLAG_TEST);

    // ------------------------------------------------------------
    // Run control and source select
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            running <= 1'b0;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_HALT)) begin
            running <= 1'b0;
        end else if (cmd_wr &&
                     (is_cmd(wdata, itec_pkg::CMD_START_INTERVAL) ||
                      is_cmd(wdata, itec_pkg::CMD_START_EVENT))) begin
            running <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src <= itec_pkg::ITEC_SRC_INTERVAL;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_START_EVENT)) begin
            src <= itec_pkg::ITEC_SRC_EVENT;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_START_INTERVAL)) begin
            src <= itec_pkg::ITEC_SRC_INTERVAL;
        end
    end

    // ------------------------------------------------------------
    // Interval source: divide the cycle strobe by 32
    // ------------------------------------------------------------
    // Prescaler only runs in interval mode so a restart is phase-clean
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescale <= 5'h00;
        end else if (!running || src != itec_pkg::ITEC_SRC_INTERVAL) begin
            prescale <= 5'h00;
        end else if (ticks.cycle_tick) begin
            prescale <= prescale + 5'h01;
        end
    end

    assign interval_pulse = ticks.cycle_tick &&
        (prescale == itec_pkg::PRESCALE_LAST);

    // ------------------------------------------------------------
    // Event source: synchronise, sample per cycle, falling edge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= count_input_pin;
            pin_sync <= pin_meta;
        end
    end

    // A low counts only after a sampled high; pulses shorter than a
    // machine cycle may be missed, as the source is told to avoid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_prev <= 1'b0;
        end else if (ticks.cycle_tick) begin
            pin_prev <= pin_sync;
        end
    end

    assign event_pulse = ticks.cycle_tick && pin_prev && !pin_sync;

    assign count_pulse = running &&
        ((src == itec_pkg::ITEC_SRC_EVENT) ? event_pulse
                                           : interval_pulse);

    // ------------------------------------------------------------
    // Count register
    // ------------------------------------------------------------
    // A load in the same cycle as an increment wins and ends the wrap
    assign wrap = count_pulse && !load_wr &&
        (count == itec_pkg::COUNT_MAX);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= itec_pkg::COUNT_RESET;
        end else if (load_wr) begin
            count <= wdata;
        end else if (count_pulse) begin
            count <= wrap_inc(count);
        end
    end

    // Set wins over the test-and-clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (flag_test) begin
            overflow_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_irq_en <= 1'b0;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_ALLOW_COUNT_IRQ)) begin
            count_irq_en <= 1'b1;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_BLOCK_COUNT_IRQ)) begin
            count_irq_en <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_irq_en <= 1'b0;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_ALLOW_HOST_IRQ)) begin
            host_irq_en <= 1'b1;
        end else if (cmd_wr &&
                     is_cmd(wdata, itec_pkg::CMD_BLOCK_HOST_IRQ)) begin
            host_irq_en <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Request latches
    // ------------------------------------------------------------
    // Disabling does not drop a pending request; only entry does
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_pending <= 1'b0;
        end else if (wrap) begin
            timer_pending <= 1'b1;
        end else if (irq_state == itec_pkg::ITEC_IRQ_CALL && int_ack &&
                     int_vector == itec_pkg::VEC_TIMER) begin
            timer_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_pending <= 1'b0;
        end else if (host_in_full) begin
            host_pending <= 1'b1;
        end else if (irq_state == itec_pkg::ITEC_IRQ_CALL && int_ack &&
                     int_vector == itec_pkg::VEC_HOST) begin
            host_pending <= 1'b0;
        end
    end

    assign host_want = host_pending && host_irq_en;
    assign timer_want = timer_pending && count_irq_en;
    assign any_want = host_want || timer_want;

    // ------------------------------------------------------------
    // Single-level vectoring
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_state <= itec_pkg::ITEC_IRQ_IDLE;
            int_vector <= itec_pkg::VEC_NONE;
        end else begin
            case (irq_state)
                itec_pkg::ITEC_IRQ_IDLE: begin
                    if (host_want) begin
                        irq_state <= itec_pkg::ITEC_IRQ_CALL;
                        int_vector <= itec_pkg::VEC_HOST;
                    end else if (any_want) begin
                        irq_state <= itec_pkg::ITEC_IRQ_CALL;
                        int_vector <= itec_pkg::VEC_TIMER;
                    end
                end
                itec_pkg::ITEC_IRQ_CALL: begin
                    if (int_ack) begin
                        irq_state <= itec_pkg::ITEC_IRQ_SERVICE;
                    end
                end
                itec_pkg::ITEC_IRQ_SERVICE: begin
                    // Pending timer request is taken straight after return
                    if (int_ret) begin
                        irq_state <= itec_pkg::ITEC_IRQ_IDLE;
                        int_vector <= itec_pkg::VEC_NONE;
                    end
                end
                default: begin
                    irq_state <= itec_pkg::ITEC_IRQ_IDLE;
                    int_vector <= itec_pkg::VEC_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_req <= 1'b0;
        end else begin
            int_req <= (irq_state == itec_pkg::ITEC_IRQ_IDLE) && any_want
                || (irq_state == itec_pkg::ITEC_IRQ_CALL)
                && !int_ack;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign status = '{
        overflow_flag: overflow_flag,
        in_service: (irq_state == itec_pkg::ITEC_IRQ_SERVICE),
        host_irq_en: host_irq_en,
        host_pending: host_pending,
        timer_pending: timer_pending,
        count_irq_en: count_irq_en,
        event_mode: (src == itec_pkg::ITEC_SRC_EVENT),
        running: running
    };

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= itec_pkg::READ_ZERO;
        end else if (rd) begin
            case (addr)
                itec_pkg::REG_COUNT: rdata <= count;
                itec_pkg::REG_FLAG_TEST:
                    rdata <= {7'h00, overflow_flag};
                itec_pkg::REG_STATUS: rdata <= status;
                default: rdata <= itec_pkg::READ_ZERO;
            endcase
        end else begin
            rdata <= itec_pkg::READ_ZERO;
        end
    end

endmodule : itec_counter

/* verification/itec_counter_properties.sv */
// Port checker for the interval timer and event counter.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ns
module itec_counter_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic int_ack,
    input wire logic machine_cycle_strobe,
    input wire logic int_req,
    input wire logic [2:0] int_vector,
    input wire logic overflow_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_strobe_width;
        $rose(machine_cycle_strobe) |->
            machine_cycle_strobe[*3] ##1 !machine_cycle_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width wrong");

    property p_strobe_period;
        $rose(machine_cycle_strobe) |-> ##15 $rose(machine_cycle_strobe);
    endproperty
    a_strobe_period: assert property (p_strobe_period)
        else $error("strobe period wrong");

    property p_rdata_zero;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("read data not zero outside read");

    property p_flag_read;
        rd && addr == itec_pkg::REG_FLAG_TEST |=>
            rdata == {7'h00, $past(overflow_flag)};
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("flag test read wrong");

    property p_flag_sticky;
        overflow_flag && !(rd && addr == itec_pkg::REG_FLAG_TEST) |=>
            overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag lost without test");

    property p_reset_out;
        $rose(rst_n) |-> !overflow_flag && !int_req && rdata == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not clear after reset");

    property p_ack_drop;
        int_ack |=> !int_req;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request stays after ack");

    property p_req_hold;
        int_req && !int_ack |=> int_req && $stable(int_vector);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ack");

    property p_vec_legal;
        int_req |-> int_vector == itec_pkg::VEC_HOST ||
            int_vector == itec_pkg::VEC_TIMER;
    endproperty
    a_vec_legal: assert property (p_vec_legal)
        else $error("illegal vector");

    c_wrap: cover property ($rose(overflow_flag));
    c_host: cover property (int_req && int_vector == itec_pkg::VEC_HOST);
    c_timer: cover property (int_req && int_vector == itec_pkg::VEC_TIMER);
endmodule : itec_counter_props

bind itec_counter itec_counter_props i_itec_counter_props (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .rd(rd),
    .rdata(rdata),
    .int_ack(int_ack),
    .machine_cycle_strobe(machine_cycle_strobe),
    .int_req(int_req),
    .int_vector(int_vector),
    .overflow_flag(overflow_flag)
);

/* verification/itec_event_src.sv */
// External event source on the count input pin.
// Assumes the bench pulses go for one clock with the event count set.
`timescale 1ns/1ns
module itec_event_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [7:0] n_events,
    input wire logic slow,
    output logic pin,
    output logic busy
);
    logic [7:0] left;
    logic [6:0] phase;
    logic [6:0] hi_len;
    logic [6:0] period;

    // High over a full machine cycle so a sample always sees it
    assign hi_len = slow ? 7'h28 : 7'h14;
    // Never faster than one edge per three machine cycles
    assign period = slow ? 7'h5a : 7'h2d;
    assign pin = (left != 8'h00) && (phase < hi_len);
    assign busy = left != 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left <= 8'h00;
            phase <= 7'h00;
        end else if (go) begin
            left <= n_events;
            phase <= 7'h00;
        end else if (left != 8'h00) begin
            if (phase == period - 7'h01) begin
                phase <= 7'h00;
                left <= left - 8'h01;
            end else begin
                phase <= phase + 7'h01;
            end
        end
    end
endmodule : itec_event_src

/* verification/tb_top.sv */
// Self-checking bench for the interval timer and event counter.
// Assumes the checker is bound to the design and a 10 MHz clock.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        end \
    end
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic count_input_pin;
    logic host_in_full = 1'b0;
    logic int_ack = 1'b0;
    logic int_ret = 1'b0;
    logic machine_cycle_strobe;
    logic int_req;
    logic [2:0] int_vector;
    logic overflow_flag;
    logic ev_go = 1'b0;
    logic [7:0] ev_n = 8'h00;
    logic ev_slow = 1'b0;
    logic ev_busy;
    int bad_count = 0;
    int num_checks = 0;
    logic [7:0] rv;
    int n;

    always #50 clk = ~clk;

    itec_counter i_itec_counter (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .count_input_pin(count_input_pin), .host_in_full(host_in_full),
        .int_ack(int_ack), .int_ret(int_ret),
        .machine_cycle_strobe(machine_cycle_strobe), .int_req(int_req),
        .int_vector(int_vector), .overflow_flag(overflow_flag));
    itec_event_src i_itec_event_src (.clk(clk), .rst_n(rst_n), .go(ev_go),
        .n_events(ev_n), .slow(ev_slow), .pin(count_input_pin),
        .busy(ev_busy));

    // ------------------------------------------------------------
    // Bus and handshake helpers
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Polls the count; k is the number of two-clock reads it took
    task automatic wait_change(inout logic [7:0] v, output int k);
        logic [7:0] nv;
        k = 0;
        nv = v;
        while (nv === v && k < 600) begin
            rd_reg(itec_pkg::REG_COUNT, nv);
            k++;
        end
        v = nv;
    endtask : wait_change

    task automatic take_irq(input logic [2:0] v);
        int k;
        k = 0;
        while (int_req !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK("vector", v, int_vector);
        @(posedge clk);
        int_ack <= 1'b1;
        @(posedge clk);
        int_ack <= 1'b0;
    endtask : take_irq

    task automatic pulse_ret();
        @(posedge clk);
        int_ret <= 1'b1;
        @(posedge clk);
        int_ret <= 1'b0;
    endtask : pulse_ret

    task automatic pulse_host();
        @(posedge clk);
        host_in_full <= 1'b1;
        @(posedge clk);
        host_in_full <= 1'b0;
    endtask : pulse_host

    task automatic ev_run(input logic [7:0] cnt, input logic s);
        int k;
        @(posedge clk);
        ev_n <= cnt;
        ev_slow <= s;
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        #1;
        k = 0;
        while (ev_busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        repeat (40) @(posedge clk);
    endtask : ev_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_load();
        rd_reg(itec_pkg::REG_STATUS, rv);
        `CHK("status", 8'h00, rv);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("count", 8'h00, rv);
        wr_reg(itec_pkg::REG_COUNT, 8'ha5);
        repeat (40) @(posedge clk);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("loaded", 8'ha5, rv);
    endtask : t_reset_load

    task automatic t_interval();
        wr_reg(itec_pkg::REG_COUNT, 8'hfe);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_START_INTERVAL);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("kept", 8'hfe, rv);
        wait_change(rv, n);
        `CHK("step", 8'hff, rv);
        wait_change(rv, n);
        `CHK("wrap", 8'h00, rv);
        `CHK("reads", 240, n);
        `CHK("flag", 1'b1, overflow_flag);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_HALT);
        repeat (600) @(posedge clk);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("halted", 8'h00, rv);
        rd_reg(itec_pkg::REG_FLAG_TEST, rv);
        `CHK("test", 8'h01, rv);
        `CHK("cleared", 1'b0, overflow_flag);
        rd_reg(itec_pkg::REG_FLAG_TEST, rv);
        `CHK("test2", 8'h00, rv);
    endtask : t_interval

    task automatic t_event();
        wr_reg(itec_pkg::REG_COUNT, 8'hfd);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_START_EVENT);
        rd_reg(itec_pkg::REG_STATUS, rv);
        `CHK("mode", 2'h3, rv[1:0]);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("kept", 8'hfd, rv);
        ev_run(8'h03, 1'b0);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("events", 8'h00, rv);
        `CHK("flag", 1'b1, overflow_flag);
        ev_run(8'h02, 1'b1);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("slow", 8'h02, rv);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_HALT);
        ev_run(8'h02, 1'b0);
        rd_reg(itec_pkg::REG_COUNT, rv);
        `CHK("stopped", 8'h02, rv);
    endtask : t_event

    task automatic t_irq();
        rd_reg(itec_pkg::REG_STATUS, rv);
        `CHK("latched", 1'b1, rv[3]);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_ALLOW_HOST_IRQ);
        repeat (5) @(posedge clk);
        #1;
        `CHK("blocked", 1'b0, int_req);
        pulse_host();
        take_irq(itec_pkg::VEC_HOST);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_ALLOW_COUNT_IRQ);
        pulse_host();
        repeat (5) @(posedge clk);
        #1;
        `CHK("single", 1'b0, int_req);
        pulse_ret();
        take_irq(itec_pkg::VEC_HOST);
        pulse_ret();
        take_irq(itec_pkg::VEC_TIMER);
        rd_reg(itec_pkg::REG_STATUS, rv);
        `CHK("served", 1'b0, rv[3]);
        pulse_ret();
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_BLOCK_COUNT_IRQ);
        wr_reg(itec_pkg::REG_CMD, itec_pkg::CMD_BLOCK_HOST_IRQ);
        rd_reg(itec_pkg::REG_STATUS, rv);
        `CHK("enables", 2'h0, {rv[5], rv[2]});
    endtask : t_irq

    task automatic test_done();
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_load();
        t_interval();
        t_event();
        t_irq();
        test_done();
    end

    // Whole run is a few thousand clocks; allow ten thousand
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
endmodule : tb_top
